// ===== core/epb_pkg.sv
// package for the encoder profile parameter bank
package epb_pkg;
  // parameter numbers used as access addresses
  localparam logic [15:0] PN_ACCESS_LIMITS = 16'h03ce;
  localparam logic [15:0] PN_DO_IDENT = 16'h03cf;
  localparam logic [15:0] PN_SENSOR_FORMAT = 16'h03d3;
  localparam logic [15:0] PN_PARAM_LIST = 16'h03d4;
  localparam logic [15:0] PN_PRESET = 16'hfde8;
  localparam logic [15:0] PN_OP_STATUS = 16'hfde9;
  // element counts
  localparam logic [3:0] N_ACCESS_LIMITS = 4'h3;
  localparam logic [3:0] N_DO_IDENT = 4'h8;
  localparam logic [3:0] N_SENSOR_FORMAT = 4'h6;
  localparam logic [3:0] N_PARAM_LIST = 4'ha;
  localparam logic [3:0] N_OP_STATUS = 4'hc;
  // access-service limits
  localparam logic [31:0] ASL_MAX_BLOCK = 32'h0000_0046;
  localparam logic [31:0] ASL_MAX_PARAMS = 32'h0000_0001;
  localparam logic [31:0] ASL_MAX_LATENCY = 32'h0000_0000;
  // drive-object identification; maker code is arbitrary
  localparam logic [15:0] DOI_MAKER = 16'h0abc;
  localparam logic [15:0] DOI_TYPE = 16'h0001;
  localparam logic [15:0] DOI_CLASS = 16'h0005;
  localparam logic [15:0] DOI_SUBCLASS = 16'h4000;
  localparam logic [15:0] DOI_OBJ_ID = 16'h0001;
  // sensor format
  localparam logic [31:0] SF_HEADER = 32'h0000_5011;
  localparam logic [31:0] SF_OBJ_TYPE = 32'h0000_8000;
  localparam logic [31:0] SF_RESOLUTION = 32'h0001_0000;
  localparam logic [31:0] SF_SHIFT = 32'h0000_0000;
  localparam logic [31:0] SF_DET_RES_0 = 32'h0000_0000;
  localparam logic [31:0] SF_DET_RES_1 = 32'h0000_1000;
  localparam logic [31:0] SF_DET_RES_2 = 32'h0000_4000;
  // operating status constants
  localparam logic [31:0] OS_HEADER = 32'h000c_0101;
  localparam logic [31:0] OS_SUP_FAULTS = 32'h0000_0031;
  localparam logic [31:0] OS_WARNINGS = 32'h0000_0000;
  localparam logic [31:0] OS_PROFILE_VER = 32'h0000_0401;
  localparam logic [31:0] OS_OP_TIME = 32'h0fff_ffff;
  // operating status bit positions
  localparam int OSB_CODE_SEQ = 0;
  localparam int OSB_ADVANCED = 1;
  localparam int OSB_PRESET_CTL = 2;
  localparam int OSB_SCALING = 3;
  localparam int OSB_ALARM_CTL = 4;
  localparam int OSB_COMPAT = 5;
  localparam logic [31:0] PRESET_RESET = 32'h0000_0000;

  typedef enum logic [2:0] {
    EPB_ST_IDLE = 3'b001,
    EPB_ST_READ = 3'b010,
    EPB_ST_WRITE = 3'b100
  } epb_state_e;

  // one acyclic parameter request
  typedef struct packed {
    logic rd;
    logic wr;
    logic [15:0] pnum;
    logic [3:0] sub;
    logic [31:0] wdata;
  } epb_req_s;

  // answer to a request
  typedef struct packed {
    logic done;
    logic err;
    logic [31:0] rdata;
  } epb_rsp_s;

  // live configuration and fault sources
  typedef struct packed {
    logic [5:0] cfg;
    logic [31:0] faults;
    logic [31:0] offset;
    logic [31:0] units_per_revolution;
    logic [31:0] total_measurement_range;
    logic [31:0] vel_unit;
    logic [1:0] turns_variant;
    logic [15:0] fw_rev;
    logic [15:0] fw_year;
    logic [15:0] fw_daymonth;
  } epb_live_s;

  // derived controls for the position logic
  typedef struct packed {
    logic ccw_increasing;
    logic preset_allowed;
    logic scaling_allowed;
    logic encoder_alarms;
    logic compat_v31;
  } epb_ctl_s;
endpackage

// ===== core/epb_const_rom.sv
// constant element lookup for the read-only arrays
`timescale 1ns/1ps
module epb_const_rom
  import epb_pkg::*;
(
  input wire logic [15:0] pnum,
  input wire logic [3:0] sub,
  input wire epb_live_s live,
  output logic [31:0] value,
  output logic hit
);
  always_comb
  begin
    value = 32'h0000_0000;
    hit = 1'b1;
    case (pnum)
      PN_ACCESS_LIMITS:
      begin
        case (sub)
          4'h0: value = ASL_MAX_BLOCK;
          4'h1: value = ASL_MAX_PARAMS;
          4'h2: value = ASL_MAX_LATENCY;
          default: hit = 1'b0;
        endcase
      end
      PN_DO_IDENT:
      begin
        case (sub)
          4'h0: value = {16'h0000, DOI_MAKER};
          4'h1: value = {16'h0000, DOI_TYPE};
          4'h2: value = {16'h0000, live.fw_rev};
          4'h3: value = {16'h0000, live.fw_year};
          4'h4: value = {16'h0000, live.fw_daymonth};
          4'h5: value = {16'h0000, DOI_CLASS};
          4'h6: value = {16'h0000, DOI_SUBCLASS};
          4'h7: value = {16'h0000, DOI_OBJ_ID};
          default: hit = 1'b0;
        endcase
      end
      PN_SENSOR_FORMAT:
      begin
        case (sub)
          4'h0: value = SF_HEADER;
          4'h1: value = SF_OBJ_TYPE;
          4'h2: value = SF_RESOLUTION;
          4'h3: value = SF_SHIFT;
          4'h4: value = SF_SHIFT;
          4'h5:
          begin
            case (live.turns_variant)
              2'h1: value = SF_DET_RES_1;
              2'h2: value = SF_DET_RES_2;
              default: value = SF_DET_RES_0;
            endcase
          end
          default: hit = 1'b0;
        endcase
      end
      PN_PARAM_LIST:
      begin
        case (sub)
          4'h0: value = 32'h0000_039a;
          4'h1: value = 32'h0000_039d;
          4'h2: value = 32'h0000_03c4;
          4'h3: value = 32'h0000_03c5;
          4'h4: value = 32'h0000_03cb;
          4'h5: value = {16'h0000, PN_ACCESS_LIMITS};
          4'h6: value = {16'h0000, PN_DO_IDENT};
          4'h7: value = {16'h0000, PN_SENSOR_FORMAT};
          4'h8: value = {16'h0000, PN_PRESET};
          4'h9: value = {16'h0000, PN_OP_STATUS};
          default: hit = 1'b0;
        endcase
      end
      default: hit = 1'b0;
    endcase
  end
endmodule

// ===== core/epb_bank.sv
// encoder profile parameter bank, acyclic access side
// Function
// - access limits report block length 70 and one parameter per request
// - third access limit element reads 0, no latency specified
// - drive-object identification returns type, class, subclass, id and firmware words
// - sensor format returns header, type, resolution 65536, zero shift factors
// - defined parameter list returns ten parameter numbers in order
// - preset is a readable writable 32-bit word below measurement range
// - preset only applies when the cyclic handshake requests it
// - status header 0x000C0101 and operating time 0xFFFFFFF
// - status reports profile version 0x00000401
// - warning and supported warning words always read zero
// - supported fault word is constant 0x31
// - fault word bits follow live supported faults
// - code sequence bit selects direction only when advanced bit set
// - advanced bit clear disables reversal, preset control and scaling
// - primary position preset allowed only with bit1 set, bit2 clear
// - scaling allowed only with bits 1 and 3 both set
// - alarm bit selects whether encoder faults go to alarm channel
// - bit 5 reports incompatibility with older profile V3.1
// - parameters are reached by acyclic record transfers, apart from cyclic data
`timescale 1ns/1ps
module epb_bank
  import epb_pkg::*;
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire epb_req_s req,
  output epb_rsp_s rsp,
  input wire epb_live_s live,
  input wire logic preset_apply,
  output logic [31:0] preset_out,
  output logic preset_strobe,
  output epb_ctl_s ctl
);
  epb_state_e state;
  epb_state_e next_state;
  epb_req_s held;
  logic [31:0] preset_value;
  logic [31:0] op_status_word;
  logic [31:0] rom_value;
  logic rom_hit;
  logic [31:0] status_value;
  logic status_hit;
  logic [31:0] read_value;
  logic read_hit;
  logic write_ok;
  logic preset_apply_d;
  epb_rsp_s next_rsp;

  epb_const_rom epb_const_rom_i (
    .pnum(held.pnum),
    .sub(held.sub),
    .live(live),
    .value(rom_value),
    .hit(rom_hit)
  );

  // configuration word, only six low bits defined
  assign op_status_word = {26'h000_0000, live.cfg};

  // derived controls
  assign ctl.ccw_increasing = live.cfg[OSB_ADVANCED] & live.cfg[OSB_CODE_SEQ];
  assign ctl.preset_allowed = live.cfg[OSB_ADVANCED] & ~live.cfg[OSB_PRESET_CTL];
  assign ctl.scaling_allowed = live.cfg[OSB_ADVANCED] & live.cfg[OSB_SCALING];
  assign ctl.encoder_alarms = live.cfg[OSB_ALARM_CTL];
  assign ctl.compat_v31 = ~live.cfg[OSB_COMPAT];

  always_comb
  begin
    status_value = 32'h0000_0000;
    status_hit = 1'b1;
    case (held.sub)
      4'h0: status_value = OS_HEADER;
      4'h1: status_value = op_status_word;
      4'h2: status_value = live.faults & OS_SUP_FAULTS;
      4'h3: status_value = OS_SUP_FAULTS;
      4'h4: status_value = OS_WARNINGS;
      4'h5: status_value = OS_WARNINGS;
      4'h6: status_value = OS_PROFILE_VER;
      4'h7: status_value = OS_OP_TIME;
      4'h8: status_value = live.offset;
      4'h9: status_value = live.units_per_revolution;
      4'ha: status_value = live.total_measurement_range;
      4'hb: status_value = live.vel_unit;
      default: status_hit = 1'b0;
    endcase
  end

  // single-value parameter only answers subindex 0
  assign read_hit = (held.pnum == PN_PRESET) ? (held.sub == 4'h0) :
                    (held.pnum == PN_OP_STATUS) ? status_hit : rom_hit;
  assign read_value = (held.pnum == PN_PRESET) ? preset_value :
                      (held.pnum == PN_OP_STATUS) ? status_value : rom_value;
  // only the preset accepts writes, and only in range
  assign write_ok = (held.pnum == PN_PRESET) && (held.sub == 4'h0) &&
                    (held.wdata < live.total_measurement_range);

  // one request in flight, answered two cycles after it is taken
  always_comb
  begin
    next_state = state;
    next_rsp = '0;
    case (state)
      EPB_ST_IDLE:
      begin
        if (req.rd)
          next_state = EPB_ST_READ;
        else if (req.wr)
          next_state = EPB_ST_WRITE;
      end
      EPB_ST_READ:
      begin
        next_state = EPB_ST_IDLE;
        next_rsp.done = 1'b1;
        next_rsp.err = ~read_hit;
        next_rsp.rdata = read_hit ? read_value : 32'h0000_0000;
      end
      EPB_ST_WRITE:
      begin
        next_state = EPB_ST_IDLE;
        next_rsp.done = 1'b1;
        next_rsp.err = ~write_ok;
      end
      default: next_state = EPB_ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state <= EPB_ST_IDLE;
      held <= '0;
      rsp <= '0;
    end
    else
    begin
      state <= next_state;
      rsp <= next_rsp;
      if (state == EPB_ST_IDLE)
        held <= req;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      preset_value <= PRESET_RESET;
    else if (state == EPB_ST_WRITE && write_ok)
      preset_value <= held.wdata;
  end

  // stored value handed on only on a rising apply request
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      preset_apply_d <= 1'b0;
      preset_out <= PRESET_RESET;
      preset_strobe <= 1'b0;
    end
    else
    begin
      preset_apply_d <= preset_apply;
      preset_strobe <= preset_apply & ~preset_apply_d;
      if (preset_apply & ~preset_apply_d)
        preset_out <= preset_value;
    end
  end
endmodule

// ===== verif/epb_bank_asserts.sv
// assertion checker for the encoder profile parameter bank ports
`timescale 1ns/1ps
module epb_bank_asserts
  import epb_pkg::*;
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire epb_req_s req,
  input wire epb_rsp_s rsp,
  input wire epb_live_s live,
  input wire logic preset_apply,
  input wire logic [31:0] preset_out,
  input wire logic preset_strobe,
  input wire epb_ctl_s ctl
);
  wire take = req.rd | req.wr;
  wire rd_lim = req.rd && req.pnum == PN_ACCESS_LIMITS && req.sub == 4'h0;
  wire rd_sup = req.rd && req.pnum == PN_OP_STATUS && req.sub == 4'h3;
  wire rd_flt = req.rd && req.pnum == PN_OP_STATUS && req.sub == 4'h2;
  wire wr_big = req.wr && !req.rd && req.pnum == PN_PRESET &&
    req.wdata >= live.total_measurement_range;
  wire wr_ro = req.wr && !req.rd && req.pnum != PN_PRESET;
  wire [4:0] ctl_exp = {live.cfg[1] & live.cfg[0], live.cfg[1] & ~live.cfg[2],
    live.cfg[1] & live.cfg[3], live.cfg[4], ~live.cfg[5]};
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  a_done_cause: assert property (rsp.done |-> $past(take, 2))
    else $error("answer without a request");
  a_done_pulse: assert property (rsp.done |=> !rsp.done)
    else $error("answer longer than one cycle");
  a_rdata_quiet: assert property (!rsp.done |-> rsp.rdata == 32'h0000_0000)
    else $error("read data outside answer");
  a_limit_block: assert property (rsp.done && $past(rd_lim, 2) |->
    rsp.rdata == 32'h0000_0046)
    else $error("wrong block length");
  a_sup_fault: assert property (rsp.done && $past(rd_sup, 2) |->
    rsp.rdata == 32'h0000_0031)
    else $error("wrong supported faults");
  a_fault_mask: assert property (rsp.done && $past(rd_flt, 2) |->
    rsp.rdata == (live.faults & 32'h0000_0031))
    else $error("wrong fault word");
  a_write_range: assert property (rsp.done && $past(wr_big, 2) |-> rsp.err)
    else $error("out of range preset taken");
  a_ro_refuse: assert property (rsp.done && $past(wr_ro, 2) |-> rsp.err)
    else $error("read-only write accepted");
  a_adv_off: assert property (!live.cfg[1] |->
    !ctl.ccw_increasing && !ctl.preset_allowed && !ctl.scaling_allowed)
    else $error("advanced functions not disabled");
  a_ctl_map: assert property (ctl == ctl_exp)
    else $error("control decode wrong");
  a_strobe_rise: assert property ($rose(preset_apply) |=> preset_strobe)
    else $error("apply without strobe");
  a_strobe_cause: assert property (preset_strobe |->
    $past(preset_apply) && !$past(preset_apply, 2))
    else $error("strobe without apply");
  a_out_hold: assert property (!preset_strobe |-> $stable(preset_out))
    else $error("preset output moved without apply");
endmodule

bind epb_bank epb_bank_asserts epb_bank_asserts_i (.ref_clk, .nrst, .req, .rsp, .live,
  .preset_apply, .preset_out, .preset_strobe, .ctl);

// ===== verif/epb_ctl_model.sv
// network controller model issuing acyclic parameter requests
`timescale 1ns/1ps
module epb_ctl_model
  import epb_pkg::*;
(
  input wire logic ref_clk,
  input wire epb_rsp_s rsp,
  output epb_req_s req
);
  int n;
  logic hung = 1'b0;
  initial req = '0;
  // one record transfer, held one cycle; rd and wr clear, other fields go to their inverse afterwards
  task xfer(input logic w, input logic [15:0] p, input logic [3:0] s, input logic [31:0] d,
    output logic e, output logic [31:0] q);
    @(negedge ref_clk);
    req = '{rd: !w, wr: w, pnum: p, sub: s, wdata: d};
    @(negedge ref_clk);
    req = '{rd: 1'b0, wr: 1'b0, pnum: ~p, sub: ~s, wdata: ~d};
    for (n = 0; n < 4 && rsp.done !== 1'b1; n++)
      @(negedge ref_clk);
    hung = rsp.done !== 1'b1;
    e = rsp.err;
    q = rsp.rdata;
  endtask
endmodule

// ===== verif/epb_bank_tb_top.sv
// self-checking testbench for the encoder profile parameter bank
`timescale 1ns/1ps
module epb_bank_tb_top
  import epb_pkg::*;
;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic preset_apply = 1'b0;
  epb_req_s req;
  epb_rsp_s rsp;
  epb_live_s live = '0;
  logic [31:0] preset_out;
  logic preset_strobe;
  epb_ctl_s ctl;
  logic e;
  logic [31:0] q;
  int i;
  int mismatches = 0;
  int checks_done = 0;
  always #4 ref_clk = ~ref_clk;
  epb_bank epb_bank_i (.ref_clk, .nrst, .req, .rsp, .live, .preset_apply, .preset_out,
    .preset_strobe, .ctl);
  epb_ctl_model epb_ctl_model_i (.ref_clk, .rsp, .req);
  task close_out;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] s, input logic [31:0] x);
    checks_done++;
    if (s !== x)
    begin
      $display("[ERR] %s exp %h got %h", n, x, s);
      mismatches++;
    end
  endtask
  // reads compare data, writes only the error flag
  task xchk(input logic w, input logic [15:0] p, input logic [3:0] s, input logic [31:0] d,
    input logic ee);
    epb_ctl_model_i.xfer(w, p, s, d, e, q);
    if (epb_ctl_model_i.hung)
    begin
      mismatches++;
      close_out;
    end
    chk("err", {31'h0, e}, {31'h0, ee});
    if (!w)
      chk("rdata", q, d);
  endtask
  task t_limits;
    xchk(1'b0, PN_ACCESS_LIMITS, 4'h0, 32'h0000_0046, 1'b0);
    xchk(1'b0, PN_ACCESS_LIMITS, 4'h1, 32'h0000_0001, 1'b0);
    xchk(1'b0, PN_ACCESS_LIMITS, 4'h2, 32'h0000_0000, 1'b0);
    xchk(1'b0, PN_ACCESS_LIMITS, 4'h3, 32'h0000_0000, 1'b1);
    xchk(1'b0, 16'h0001, 4'h0, 32'h0000_0000, 1'b1);
  endtask
  task t_ident;
    logic [15:0] di [8];
    di = '{DOI_MAKER, 16'h0001, live.fw_rev, live.fw_year, live.fw_daymonth, 16'h0005,
      16'h4000, 16'h0001};
    for (i = 0; i < 8; i++)
      xchk(1'b0, PN_DO_IDENT, 4'(i), {16'h0000, di[i]}, 1'b0);
  endtask
  task t_sensor;
    logic [31:0] sf [5];
    logic [31:0] dr [4];
    sf = '{32'h0000_5011, 32'h0000_8000, 32'h0001_0000, '0, '0};
    dr = '{'0, 32'h0000_1000, 32'h0000_4000, '0};
    for (i = 0; i < 5; i++)
      xchk(1'b0, PN_SENSOR_FORMAT, 4'(i), sf[i], 1'b0);
    for (i = 0; i < 4; i++)
    begin
      live.turns_variant = 2'(i);
      xchk(1'b0, PN_SENSOR_FORMAT, 4'h5, dr[i], 1'b0);
    end
  endtask
  task t_list;
    logic [15:0] pl [10];
    pl = '{16'h039a, 16'h039d, 16'h03c4, 16'h03c5, 16'h03cb, 16'h03ce,
      16'h03cf, 16'h03d3, 16'hfde8, 16'hfde9};
    for (i = 0; i < 10; i++)
      xchk(1'b0, PN_PARAM_LIST, 4'(i), {16'h0000, pl[i]}, 1'b0);
    xchk(1'b1, PN_PARAM_LIST, 4'h0, 32'h0000_0001, 1'b1);
  endtask
  task t_status;
    live.faults = 32'hffff_fff0;
    live.cfg = 6'h2a;
    xchk(1'b0, PN_OP_STATUS, 4'h0, 32'h000c_0101, 1'b0);
    xchk(1'b0, PN_OP_STATUS, 4'h1, 32'h0000_002a, 1'b0);
    xchk(1'b0, PN_OP_STATUS, 4'h2, 32'h0000_0030, 1'b0);
    xchk(1'b0, PN_OP_STATUS, 4'h3, 32'h0000_0031, 1'b0);
    xchk(1'b0, PN_OP_STATUS, 4'h4, 32'h0000_0000, 1'b0);
    xchk(1'b0, PN_OP_STATUS, 4'h5, 32'h0000_0000, 1'b0);
    xchk(1'b0, PN_OP_STATUS, 4'h6, 32'h0000_0401, 1'b0);
    xchk(1'b0, PN_OP_STATUS, 4'h7, 32'h0fff_ffff, 1'b0);
    live.offset = 32'h1234_5678;
    live.units_per_revolution = 32'h0000_8000;
    live.vel_unit = 32'h0000_0003;
    xchk(1'b0, PN_OP_STATUS, 4'h8, 32'h1234_5678, 1'b0);
    xchk(1'b0, PN_OP_STATUS, 4'h9, 32'h0000_8000, 1'b0);
    xchk(1'b0, PN_OP_STATUS, 4'ha, 32'h0001_0000, 1'b0);
    xchk(1'b0, PN_OP_STATUS, 4'hb, 32'h0000_0003, 1'b0);
    xchk(1'b0, PN_OP_STATUS, 4'hc, 32'h0000_0000, 1'b1);
    xchk(1'b1, PN_OP_STATUS, 4'h1, 32'h0000_0000, 1'b1);
  endtask
  task t_preset;
    xchk(1'b1, PN_PRESET, 4'h0, 32'h0000_ffff, 1'b0);
    xchk(1'b0, PN_PRESET, 4'h0, 32'h0000_ffff, 1'b0);
    chk("preset_out", preset_out, 32'h0000_0000);
    xchk(1'b1, PN_PRESET, 4'h0, 32'h0001_0000, 1'b1);
    xchk(1'b1, PN_ACCESS_LIMITS, 4'h0, 32'h0000_0005, 1'b1);
    xchk(1'b0, PN_ACCESS_LIMITS, 4'h0, 32'h0000_0046, 1'b0);
    xchk(1'b1, PN_PRESET, 4'h1, 32'h0000_0001, 1'b1);
    xchk(1'b0, PN_PRESET, 4'h1, 32'h0000_0000, 1'b1);
    xchk(1'b0, PN_PRESET, 4'h0, 32'h0000_ffff, 1'b0);
    preset_apply = 1'b1;
    @(negedge ref_clk);
    chk("strobe", {31'h0, preset_strobe}, 32'h0000_0001);
    chk("preset_out", preset_out, 32'h0000_ffff);
    @(negedge ref_clk);
    chk("strobe", {31'h0, preset_strobe}, 32'h0000_0000);
    preset_apply = 1'b0;
  endtask
  task t_cfg;
    for (i = 0; i < 64; i++)
    begin
      @(negedge ref_clk);
      live.cfg = 6'(i);
      #1 chk("ctl", {27'h0, ctl}, {27'h0, live.cfg[1] & live.cfg[0], live.cfg[1] & ~live.cfg[2],
        live.cfg[1] & live.cfg[3], live.cfg[4], ~live.cfg[5]});
    end
  endtask
  initial
  begin
    live.fw_rev = 16'h1357;
    live.fw_year = 16'h2468;
    live.fw_daymonth = 16'h0a0b;
    live.total_measurement_range = 32'h0001_0000;
    repeat (6) @(negedge ref_clk);
    nrst = 1'b1;
    t_limits;
    t_ident;
    t_sensor;
    t_list;
    t_status;
    t_preset;
    t_cfg;
    nrst = 1'b0;
    repeat (2) @(negedge ref_clk);
    nrst = 1'b1;
    chk("preset_out", preset_out, 32'h0000_0000);
    xchk(1'b0, PN_PRESET, 4'h0, 32'h0000_0000, 1'b0);
    close_out;
  end
endmodule
